// ---- rtl/hdrp_read_port.sv ----
// Read side of the host memory port with the overlay mode bit.
//
// How it works
// - long read: word on bus before ack
// - ack high at start; release bus at end
// - short read drives previously fetched word
// - program words come as two halves
// - fresh word on long read needs bit 14 clear
// - short-read-only bit clear after reset
// - bit 14 at 0x3FE7 selects short-read-only
// - core and host both write the bit
// - short-read-only holds previous word to end
`timescale 1ns/1ps
`default_nettype none

module hdrp_read_port #(
    parameter int DM_DEPTH = 16384,
    parameter int PM_DEPTH = 16384
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic port_select_n,
    input wire logic port_read_strobe_n,
    input wire hdrp_pkg::hdrp_host_addr_type host_addr,
    input wire logic host_ovl_wr,
    input wire logic [hdrp_pkg::BUS_W-1:0] host_ovl_data,
    input wire hdrp_pkg::hdrp_core_wr_type core_wr,
    output logic port_acknowledge_n,
    output logic [hdrp_pkg::BUS_W-1:0] port_addr_data_bus_out,
    output logic port_addr_data_bus_oe_n,
    output logic short_read_only
);
    import hdrp_pkg::*;

    initial begin
        if (DM_DEPTH > (1 << ADDR_W) || PM_DEPTH > (1 << ADDR_W)) begin
            $error("hdrp_read_port: memory depth exceeds address range");
        end
    end

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    hdrp_state_type state_r, state_nxt;
    logic act_r, act_nxt;
    logic ack_n_r, ack_n_nxt;
    logic oe_n_r, oe_n_nxt;
    logic [BUS_W-1:0] bus_r, bus_nxt;
    logic [BUS_W-1:0] prev_word_r, prev_word_nxt;
    logic [PM_W-1:0] pm_word_r, pm_word_nxt;
    logic half_r, half_nxt;
    hdrp_space_type space_r, space_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [BUS_W-1:0] ovl_r, ovl_nxt;

    logic reading;
    logic rise;
    logic dm_re, pm_re, dm_we, pm_we;
    logic [BUS_W-1:0] dm_rd;
    logic [PM_W-1:0] pm_rd;
    logic [BUS_W-1:0] new_word;

    // Read is live only while both strobes are low
    assign reading = !port_select_n && !port_read_strobe_n;
    assign rise = reading && !act_r;
    assign dm_we = core_wr.we && core_wr.space == HDRP_SPACE_DM;
    assign pm_we = core_wr.we && core_wr.space == HDRP_SPACE_PM;

    // ----------------------------------------------------------------
    // Memories
    // ----------------------------------------------------------------
    hdrp_mem #(.WIDTH(BUS_W), .DEPTH(DM_DEPTH), .AW(ADDR_W)) u_dm (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .we(dm_we),
        .wr_addr(core_wr.addr),
        .wr_data(core_wr.data[BUS_W-1:0]),
        .re(dm_re),
        .rd_addr(addr_r),
        .rd_data_r(dm_rd)
    );

    hdrp_mem #(.WIDTH(PM_W), .DEPTH(PM_DEPTH), .AW(ADDR_W)) u_pm (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .we(pm_we),
        .wr_addr(core_wr.addr),
        .wr_data(core_wr.data),
        .re(pm_re),
        .rd_addr(addr_r),
        .rd_data_r(pm_rd)
    );

    // ----------------------------------------------------------------
    // Overlay register
    // ----------------------------------------------------------------
    // Host write is taken after the core write so a collision keeps it
    always_comb begin
        ovl_nxt = ovl_r;
        if (dm_we && core_wr.addr == OVL_ADDR) begin
            ovl_nxt = core_wr.data[BUS_W-1:0];
        end
        if (host_ovl_wr) begin
            ovl_nxt = host_ovl_data;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ovl_r <= OVL_RESET;
        end else begin
            ovl_r <= ovl_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Read sequencer
    // ----------------------------------------------------------------
    // The bus opens with the previous word, except a plain-mode program second half, which opens with that half; only a read
    // still live in the fetch cycle in plain mode later swaps in the freshly fetched one. A read that ends
    // early still lets the fetch finish so the next read can replay it.
    always_comb begin
        state_nxt = state_r;
        act_nxt = reading;
        ack_n_nxt = ack_n_r;
        oe_n_nxt = oe_n_r;
        bus_nxt = bus_r;
        prev_word_nxt = prev_word_r;
        pm_word_nxt = pm_word_r;
        half_nxt = half_r;
        space_nxt = space_r;
        addr_nxt = addr_r;
        dm_re = 1'b0;
        pm_re = 1'b0;
        new_word = (space_r == HDRP_SPACE_PM) ? pm_rd[PM_W-1:HALF2_W]
                                              : dm_rd;
        if (rise) begin
            oe_n_nxt = 1'b0;
            bus_nxt = prev_word_r;
        end
        if (!reading) begin
            oe_n_nxt = 1'b1;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (host_addr.load) begin
                    space_nxt = host_addr.space;
                    addr_nxt = host_addr.addr;
                    half_nxt = 1'b0;
                end else if (rise) begin
                    ack_n_nxt = 1'b1;
                    if (space_r == HDRP_SPACE_PM && half_r) begin
                        // Second half needs no fetch, hence shorter hold
                        prev_word_nxt = {{(BUS_W-HALF2_W){1'b0}},
                                         pm_word_r[HALF2_W-1:0]};
                        if (!ovl_r[OVL_SRO_BIT]) begin
                            bus_nxt = prev_word_nxt;
                        end
                        half_nxt = 1'b0;
                        addr_nxt = addr_r + 1'b1;
                        state_nxt = ST_SETUP;
                    end else begin
                        dm_re = space_r == HDRP_SPACE_DM;
                        pm_re = space_r == HDRP_SPACE_PM;
                        state_nxt = ST_FETCH;
                    end
                end
            end
            ST_FETCH: begin
                prev_word_nxt = new_word;
                if (space_r == HDRP_SPACE_PM) begin
                    pm_word_nxt = pm_rd;
                    half_nxt = 1'b1;
                end else begin
                    addr_nxt = addr_r + 1'b1;
                end
                if (reading && !ovl_r[OVL_SRO_BIT]) begin
                    bus_nxt = new_word;
                end
                state_nxt = ST_SETUP;
            end
            ST_SETUP: begin
                // Bus settled one edge earlier than acknowledge falls
                ack_n_nxt = 1'b0;
                // A read that already ended goes straight back to idle, so
                // a start seen once acknowledge shows ready is not lost
                state_nxt = reading ? ST_DONE : ST_IDLE;
            end
            ST_DONE: begin
                // Host keeps the read past acknowledge; wait for its end
                if (!reading) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IDLE;
            act_r <= 1'b0;
            ack_n_r <= 1'b0;
            oe_n_r <= 1'b1;
            bus_r <= WORD_RESET;
            prev_word_r <= WORD_RESET;
            pm_word_r <= '0;
            half_r <= 1'b0;
            space_r <= HDRP_SPACE_DM;
            addr_r <= '0;
        end else begin
            state_r <= state_nxt;
            act_r <= act_nxt;
            ack_n_r <= ack_n_nxt;
            oe_n_r <= oe_n_nxt;
            bus_r <= bus_nxt;
            prev_word_r <= prev_word_nxt;
            pm_word_r <= pm_word_nxt;
            half_r <= half_nxt;
            space_r <= space_nxt;
            addr_r <= addr_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign port_acknowledge_n = ack_n_r;
    assign port_addr_data_bus_out = bus_r;
    assign port_addr_data_bus_oe_n = oe_n_r;
    assign short_read_only = ovl_r[OVL_SRO_BIT];

endmodule
`default_nettype wire

// ---- rtl/hdrp_pkg.sv ----
// Shared constants and carrier types of the host memory port read side.
package hdrp_pkg;

    // ----------------------------------------------------------------
    // Widths and map
    // ----------------------------------------------------------------
    localparam int BUS_W = 16;
    localparam int PM_W = 24;
    localparam int ADDR_W = 14;
    localparam int HALF2_W = PM_W - BUS_W;
    localparam logic [ADDR_W-1:0] OVL_ADDR = 14'h3FE7;
    localparam int OVL_SRO_BIT = 14;
    localparam logic [BUS_W-1:0] OVL_RESET = 16'h0000;
    localparam logic [BUS_W-1:0] WORD_RESET = 16'h0000;

    // ----------------------------------------------------------------
    // Timing (200 MHz system clock)
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ACK_HIGH_MAX_NS = 17;
    localparam int ACK_HIGH_MAX_CYC = (ACK_HIGH_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int SRO_READ_MIN_NS = 10;
    localparam int SRO_READ_MIN_CYC =
        (SRO_READ_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int FETCH_CYC = 2;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {
        HDRP_SPACE_DM,
        HDRP_SPACE_PM
    } hdrp_space_type;

    typedef struct packed {
        logic we;
        hdrp_space_type space;
        logic [ADDR_W-1:0] addr;
        logic [PM_W-1:0] data;
    } hdrp_core_wr_type;

    typedef struct packed {
        logic load;
        hdrp_space_type space;
        logic [ADDR_W-1:0] addr;
    } hdrp_host_addr_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_SETUP,
        ST_DONE
    } hdrp_state_type;

endpackage

// ---- rtl/hdrp_mem.sv ----
// Simple dual-port memory with registered read data and a core write port.
`timescale 1ns/1ps
`default_nettype none

module hdrp_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16384,
    parameter int AW = 14
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic we,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [WIDTH-1:0] wr_data,
    input wire logic re,
    input wire logic [AW-1:0] rd_addr,
    output logic [WIDTH-1:0] rd_data_r
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rd_data_nxt;

    initial begin
        if (DEPTH > (1 << AW) || WIDTH < 1) begin
            $error("hdrp_mem: depth does not fit the address width");
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    // Hold the last word when idle so the port can replay it
    always_comb begin
        rd_data_nxt = re ? mem[rd_addr] : rd_data_r;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_r <= '0;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end

    // Array itself carries no reset; contents are undefined until written
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[wr_addr] <= wr_data;
        end
    end

endmodule
`default_nettype wire

// ---- tb/hdrp_read_port_chk.sv ----
// Concurrent checks on the pins of the host memory port read side.
`timescale 1ns/1ps
`default_nettype none

module hdrp_read_port_chk
    import hdrp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic port_select_n,
    input wire logic port_read_strobe_n,
    input wire logic host_ovl_wr,
    input wire logic [hdrp_pkg::BUS_W-1:0] host_ovl_data,
    input wire hdrp_pkg::hdrp_core_wr_type core_wr,
    input wire logic port_acknowledge_n,
    input wire logic [hdrp_pkg::BUS_W-1:0] port_addr_data_bus_out,
    input wire logic port_addr_data_bus_oe_n,
    input wire logic short_read_only
);
    logic act;
    logic act_d;
    logic st;
    logic ovl_core;
    // A start is only honoured while the port reports ready
    assign act = !port_select_n && !port_read_strobe_n;
    assign st = act && !act_d && !port_acknowledge_n;
    assign ovl_core = core_wr.we && core_wr.space == HDRP_SPACE_DM
        && core_wr.addr == OVL_ADDR;
    // Delayed read window, so one long read counts as one start
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            act_d <= 1'b0;
        end else begin
            act_d <= act;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_busy;
        st |=> port_acknowledge_n && !port_addr_data_bus_oe_n; endproperty
    a_busy: assert property (p_busy)
        else $error("no busy or no bus drive after read start");
    property p_ready; st |-> ##[2:3] !port_acknowledge_n; endproperty
    a_ready: assert property (p_ready)
        else $error("acknowledge late after read start");
    property p_data_first; act && $fell(port_acknowledge_n)
        && !port_addr_data_bus_oe_n |-> $stable(port_addr_data_bus_out);
    endproperty
    a_data_first: assert property (p_data_first)
        else $error("bus data changed with acknowledge");
    property p_release;
        !act && act_d && !port_addr_data_bus_oe_n |=> port_addr_data_bus_oe_n;
    endproperty
    a_release: assert property (p_release)
        else $error("bus not released after read end");
    property p_ack_keep;
        !port_acknowledge_n && !(act && !act_d) |=> !port_acknowledge_n;
    endproperty
    a_ack_keep: assert property (p_ack_keep)
        else $error("acknowledge rose without a read start");
    property p_sro_hold; short_read_only && act && act_d
        && !$past(port_addr_data_bus_oe_n) |-> $stable(port_addr_data_bus_out);
    endproperty
    a_sro_hold: assert property (p_sro_hold)
        else $error("bus word changed in short-read-only read");
    property p_reset; $rose(resetn) |-> !short_read_only
        && port_addr_data_bus_oe_n && !port_acknowledge_n; endproperty
    a_reset: assert property (p_reset)
        else $error("wrong output after reset");
    property p_core_ovl; ovl_core && !host_ovl_wr
        |=> short_read_only == $past(core_wr.data[OVL_SRO_BIT]); endproperty
    a_core_ovl: assert property (p_core_ovl)
        else $error("core overlay write not taken");
    property p_host_ovl;
        host_ovl_wr |=> short_read_only == $past(host_ovl_data[OVL_SRO_BIT]);
    endproperty
    a_host_ovl: assert property (p_host_ovl)
        else $error("host overlay write not taken");
    property p_ovl_keep;
        !ovl_core && !host_ovl_wr |=> $stable(short_read_only); endproperty
    a_ovl_keep: assert property (p_ovl_keep)
        else $error("mode bit changed without a write");
endmodule

bind hdrp_read_port hdrp_read_port_chk chk_u (
    .sys_clk(sys_clk), .resetn(resetn), .port_select_n(port_select_n),
    .port_read_strobe_n(port_read_strobe_n), .host_ovl_wr(host_ovl_wr),
    .host_ovl_data(host_ovl_data), .core_wr(core_wr),
    .port_acknowledge_n(port_acknowledge_n),
    .port_addr_data_bus_out(port_addr_data_bus_out),
    .port_addr_data_bus_oe_n(port_addr_data_bus_oe_n),
    .short_read_only(short_read_only)
);

`default_nettype wire

// ---- tb/hdrp_host_model.sv ----
// Behavioural external host driving the port pins at falling edges.
`timescale 1ns/1ps
`default_nettype none

module hdrp_host_model
    import hdrp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic port_acknowledge_n,
    input wire logic [hdrp_pkg::BUS_W-1:0] port_addr_data_bus_out,
    output logic port_select_n,
    output logic port_read_strobe_n,
    output hdrp_pkg::hdrp_host_addr_type host_addr,
    output logic host_ovl_wr,
    output logic [hdrp_pkg::BUS_W-1:0] host_ovl_data
);
    // Idle pins from time zero
    initial begin
        port_select_n = 1'b1;
        port_read_strobe_n = 1'b1;
        host_addr = '0;
        host_ovl_wr = 1'b0;
        host_ovl_data = '0;
    end
    // Leaves one idle edge after any release, then waits for ready
    task automatic idle_wait();
        @(negedge sys_clk);
        while (port_acknowledge_n) @(negedge sys_clk);
    endtask
    // Address load for one cycle
    task automatic load(input hdrp_space_type sp,
                        input logic [ADDR_W-1:0] a);
        idle_wait();
        host_addr = '{1'b1, sp, a};
        @(negedge sys_clk);
        host_addr.load = 1'b0;
    endtask
    // Mode write; short-read-only is the safe choice at this clock rate
    task automatic ovl(input logic [BUS_W-1:0] d);
        idle_wait();
        host_ovl_wr = 1'b1;
        host_ovl_data = d;
        @(negedge sys_clk);
        host_ovl_wr = 1'b0;
    endtask
    // Read: hold 0 means long read, else released after hold cycles
    task automatic rd(input int hold, output logic [BUS_W-1:0] first,
                      output logic [BUS_W-1:0] last);
        idle_wait();
        port_select_n = 1'b0;
        port_read_strobe_n = 1'b0;
        @(negedge sys_clk);
        first = port_addr_data_bus_out;
        if (hold == 0) begin
            while (port_acknowledge_n) @(negedge sys_clk);
            last = port_addr_data_bus_out;
            @(negedge sys_clk);
        end else begin
            repeat (hold - 1) @(negedge sys_clk);
            last = port_addr_data_bus_out;
        end
        port_select_n = 1'b1;
        port_read_strobe_n = 1'b1;
    endtask
endmodule

`default_nettype wire

// ---- tb/test_host_dma_read_port.sv ----
// Self-checking bench for the host memory port read side.
`timescale 1ns/1ps
`default_nettype none

module test_host_dma_read_port;
    import hdrp_pkg::*;
    logic sys_clk;
    logic resetn;
    logic sel_n;
    logic rd_n;
    hdrp_host_addr_type host_addr;
    logic ovl_wr;
    logic [BUS_W-1:0] ovl_data;
    hdrp_core_wr_type core_wr;
    logic ack_n;
    logic [BUS_W-1:0] bus;
    logic oe_n;
    logic sro;
    logic [BUS_W-1:0] w0;
    logic [BUS_W-1:0] w1;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;

    hdrp_read_port dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .port_select_n(sel_n), .port_read_strobe_n(rd_n),
        .host_addr(host_addr), .host_ovl_wr(ovl_wr),
        .host_ovl_data(ovl_data), .core_wr(core_wr),
        .port_acknowledge_n(ack_n), .port_addr_data_bus_out(bus),
        .port_addr_data_bus_oe_n(oe_n), .short_read_only(sro));
    hdrp_host_model host_u (.sys_clk(sys_clk), .port_acknowledge_n(ack_n),
        .port_addr_data_bus_out(bus), .port_select_n(sel_n),
        .port_read_strobe_n(rd_n), .host_addr(host_addr),
        .host_ovl_wr(ovl_wr), .host_ovl_data(ovl_data));

    // 200 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // A hung handshake would stall the host model forever
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic check(input logic [BUS_W-1:0] seen,
                         input logic [BUS_W-1:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // One-cycle core write, also the way the core reaches the mode bit
    task automatic cw(input hdrp_space_type sp, input logic [ADDR_W-1:0] a,
                      input logic [PM_W-1:0] d);
        @(negedge sys_clk);
        core_wr = '{1'b1, sp, a, d};
        @(negedge sys_clk);
        core_wr.we = 1'b0;
    endtask
    // Main sequence
    initial begin
        resetn = 1'b0;
        core_wr = '0;
        repeat (12) @(posedge sys_clk);
        @(negedge sys_clk);
        resetn = 1'b1;
        check(sro, 1'b0);
        check(oe_n, 1'b1);
        cw(HDRP_SPACE_DM, 14'h0010, 24'h00A5A5);
        cw(HDRP_SPACE_DM, 14'h0011, 24'h001234);
        cw(HDRP_SPACE_DM, 14'h0012, 24'h000F0F);
        cw(HDRP_SPACE_PM, 14'h0020, 24'hABCDEF);
        cw(HDRP_SPACE_PM, 14'h0021, 24'h123456);
        host_u.load(HDRP_SPACE_DM, 14'h0010);
        host_u.rd(0, w0, w1);
        check(w1, 16'hA5A5);
        host_u.rd(0, w0, w1);
        check(w0, 16'hA5A5);
        check(w1, 16'h1234);
        host_u.rd(3, w0, w1);
        check(w0, 16'h1234);
        host_u.rd(3, w0, w1);
        check(w0, 16'h0F0F);
        host_u.load(HDRP_SPACE_PM, 14'h0020);
        host_u.rd(0, w0, w1);
        check(w1, 16'hABCD);
        host_u.rd(0, w0, w1);
        check(w1, 16'h00EF);
        host_u.rd(0, w0, w1);
        check(w1, 16'h1234);
        host_u.ovl(16'h4000);
        check(sro, 1'b1);
        host_u.load(HDRP_SPACE_DM, 14'h0010);
        host_u.rd(2, w0, w1);
        check(w0, 16'h1234);
        check(w1, 16'h1234);
        host_u.rd(2, w0, w1);
        check(w0, 16'hA5A5);
        check(w1, 16'hA5A5);
        host_u.rd(SRO_READ_MIN_CYC, w0, w1);
        check(w0, 16'h1234);
        check(w1, 16'h1234);
        cw(HDRP_SPACE_DM, OVL_ADDR, 24'h000000);
        check(sro, 1'b0);
        cw(HDRP_SPACE_DM, OVL_ADDR, 24'h004000);
        check(sro, 1'b1);
        host_u.ovl(16'h0000);
        check(sro, 1'b0);
        print_verdict();
    end
endmodule

`default_nettype wire
